// *** rtl/fcs_pkg.sv ***
// package of command codes, pin timing and states for the flash command host
package fcs_pkg;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int CLK_MHZ = 40;
   localparam int PROG_PULSE_US = 10;
   localparam int PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
   localparam int PROG_MAX_TRIES = 25;
   localparam int ERASE_PULSE_MS = 10;
   localparam int ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
   localparam int ERASE_MAX_TRIES = 1000;
   localparam int STROBE_CYC = 4;
   localparam int READ_CYC = 6;
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_IDENT = 3'h1;
   localparam logic [2:0] OP_PROGRAM = 3'h2;
   localparam logic [2:0] OP_ERASE = 3'h3;
   localparam logic [2:0] OP_ABORT = 3'h4;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_WRITE = 7'h02,
      ST_GAP = 7'h04,
      ST_WAIT = 7'h08,
      ST_READ = 7'h10,
      ST_NEXT = 7'h20,
      ST_DONE = 7'h40
   } fcs_state_t;
endpackage : fcs_pkg

// *** rtl/fcs_host.sv ***
// host controller that drives a byte-wide flash through its command register
`timescale 1ns/10ps
`default_nettype none
module fcs_host
   import fcs_pkg::*;
#(
   parameter int ADDR_W = 17,
   parameter int ERASE_CYC = ERASE_PULSE_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire logic [2:0] req_op,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [7:0] req_data,
   output logic req_ready,
   output logic done_pulse,
   output logic done_fail,
   output logic [7:0] done_data,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic flash_vpp_en
);
   // refuse sizes the address counter and the pulse timer cannot serve
   if (ADDR_W < 2 || ADDR_W > 24 || ERASE_CYC < 1) begin : g_bad_params
      $error("fcs_host: bad parameters");
   end
   localparam logic [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};
   typedef struct packed {
      fcs_state_t st;
      logic [2:0] op;
      logic [2:0] step;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
      logic [7:0] wbyte;
      logic [ADDR_W-1:0] waddr;
      logic [31:0] cnt;
      logic [9:0] tries;
      logic busy;
      logic done;
      logic fail;
      logic [7:0] rdata;
      logic [ADDR_W-1:0] fa;
      logic [7:0] fd;
      logic oe_dq;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic vpp;
   } fcs_regs_t;
   fcs_regs_t r_q, r_d;
   // issue one bus write: address set before strobe falls, data held through its rise
   task automatic put_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      r_d.waddr = a;
      r_d.wbyte = d;
      r_d.st = ST_WRITE;
      r_d.cnt = 32'h0;
   endtask : put_write
   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      unique case (r_q.st)
         ST_IDLE: begin
            r_d.busy = 1'b0;
            if (req_valid) begin
               r_d.busy = 1'b1;
               r_d.op = req_op;
               r_d.addr = req_addr;
               r_d.data = req_data;
               r_d.step = 3'h0;
               r_d.tries = 10'h0;
               r_d.fail = 1'b0;
               r_d.vpp = 1'b1;
               unique case (req_op)
                  OP_IDENT: put_write(req_addr, CMD_IDENT);
                  OP_PROGRAM: put_write(req_addr, CMD_PROGRAM);
                  OP_ERASE: put_write(req_addr, CMD_ERASE);
                  OP_ABORT: put_write(req_addr, CMD_RESET);
                  default: put_write(req_addr, CMD_READ);
               endcase
            end
         end
         ST_WRITE: begin
            // chip enable low one cycle before the strobe falls, data driven throughout
            r_d.fa = r_q.waddr;
            r_d.fd = r_q.wbyte;
            r_d.oe_dq = 1'b1;
            r_d.oe_n = 1'b1;
            r_d.ce_n = 1'b0;
            r_d.cnt = r_q.cnt + 32'h1;
            // strobe falls one cycle after the address settles, so the fall captures it
            r_d.we_n = (r_q.cnt >= 32'h1 && r_q.cnt <= 32'(STROBE_CYC)) ? 1'b0 : 1'b1;
            if (r_q.cnt == 32'(STROBE_CYC + 1)) begin
               r_d.st = ST_GAP;
               r_d.cnt = 32'h0;
            end
         end
         ST_GAP: begin
            r_d.ce_n = 1'b1;
            r_d.oe_dq = 1'b0;
            r_d.cnt = 32'h0;
            r_d.st = ST_NEXT;
         end
         ST_WAIT: begin
            // pulse runs from one strobe rise to the next
            r_d.cnt = r_q.cnt + 32'h1;
            if (r_q.cnt + 32'h1 >= ((r_q.op == OP_ERASE) ? 32'(ERASE_CYC) : 32'(PROG_PULSE_CYC))) begin
               r_d.tries = r_q.tries + 10'h1;
               if (r_q.op == OP_ERASE)
                  put_write(r_q.addr, CMD_ERASE_VERIFY);
               else
                  put_write(r_q.addr, CMD_PROGRAM_VERIFY);
               r_d.step = 3'h3;
            end
         end
         ST_READ: begin
            r_d.fa = r_q.addr;
            r_d.ce_n = 1'b0;
            r_d.oe_n = 1'b0;
            r_d.oe_dq = 1'b0;
            r_d.cnt = r_q.cnt + 32'h1;
            if (r_q.cnt == 32'(READ_CYC)) begin
               r_d.rdata = flash_dq_in;
               r_d.ce_n = 1'b1;
               r_d.oe_n = 1'b1;
               r_d.st = ST_NEXT;
               r_d.step = r_q.step + 3'h1;
            end
         end
         ST_NEXT: begin
            r_d.st = ST_DONE;
            unique case (r_q.op)
               OP_IDENT: begin
                  if (r_q.step == 3'h0) begin
                     r_d.st = ST_READ;
                     r_d.cnt = 32'h0;
                  end
               end
               OP_PROGRAM: begin
                  if (r_q.step == 3'h0) begin
                     put_write(r_q.addr, r_q.data);
                     r_d.step = 3'h1;
                  end else if (r_q.step == 3'h1) begin
                     r_d.st = ST_WAIT;
                     r_d.cnt = 32'h0;
                  end else if (r_q.step == 3'h3) begin
                     r_d.st = ST_READ;
                     r_d.cnt = 32'h0;
                  end else if (r_q.step == 3'h6) begin
                     r_d.st = ST_DONE;
                  end else if (r_q.rdata == r_q.data) begin
                     put_write(r_q.addr, CMD_READ);
                     r_d.step = 3'h6;
                  end else if (r_q.tries >= 10'(PROG_MAX_TRIES)) begin
                     r_d.fail = 1'b1;
                     put_write(r_q.addr, CMD_READ);
                     r_d.step = 3'h6;
                  end else begin
                     put_write(r_q.addr, CMD_PROGRAM);
                     r_d.step = 3'h0;
                  end
               end
               OP_ERASE: begin
                  if (r_q.step == 3'h0) begin
                     put_write(r_q.addr, CMD_ERASE);
                     r_d.step = 3'h1;
                  end else if (r_q.step == 3'h1) begin
                     r_d.st = ST_WAIT;
                     r_d.cnt = 32'h0;
                  end else if (r_q.step == 3'h3) begin
                     r_d.st = ST_READ;
                     r_d.cnt = 32'h0;
                  end else if (r_q.step == 3'h6) begin
                     r_d.st = ST_DONE;
                  end else if (r_q.rdata == ERASED_BYTE) begin
                     if (r_q.addr == LAST_ADDR) begin
                        put_write(r_q.addr, CMD_READ);
                        r_d.step = 3'h6;
                     end else begin
                        r_d.addr = r_q.addr + 1'b1;
                        put_write(r_q.addr + 1'b1, CMD_ERASE_VERIFY);
                        r_d.step = 3'h3;
                     end
                  end else if (r_q.tries >= 10'(ERASE_MAX_TRIES)) begin
                     r_d.fail = 1'b1;
                     put_write(r_q.addr, CMD_READ);
                     r_d.step = 3'h6;
                  end else begin
                     put_write(r_q.addr, CMD_ERASE); // addr kept for resume
                     r_d.step = 3'h0;
                  end
               end
               OP_ABORT: begin
                  if (r_q.step == 3'h0) begin
                     put_write(r_q.addr, CMD_RESET);
                     r_d.step = 3'h1;
                  end else if (r_q.step == 3'h1) begin
                     put_write(r_q.addr, CMD_READ);
                     r_d.step = 3'h6;
                  end
               end
               default: ;
            endcase
         end
         ST_DONE: begin
            // supply stays up in read and ident modes; dropped after alteration ends
            r_d.vpp = (r_q.op == OP_IDENT || r_q.op == OP_READ);
            r_d.done = 1'b1;
            r_d.busy = 1'b0;
            r_d.st = ST_IDLE;
         end
         default: r_d.st = ST_IDLE;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         r_q <= '0;
         r_q.st <= ST_IDLE;
         r_q.ce_n <= 1'b1;
         r_q.we_n <= 1'b1;
         r_q.oe_n <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end
   assign req_ready = ~r_q.busy;
   assign done_pulse = r_q.done;
   assign done_fail = r_q.fail;
   assign done_data = r_q.rdata;
   assign flash_addr = r_q.fa;
   assign flash_dq_out = r_q.fd;
   assign flash_dq_oe = r_q.oe_dq;
   assign flash_ce_n = r_q.ce_n;
   assign flash_we_n = r_q.we_n;
   assign flash_oe_n = r_q.oe_n;
   assign flash_vpp_en = r_q.vpp;
   // independent count of pulse length, kept apart from the sequencer's own counter
   logic [9:0] pulse_len_q;
   always_ff @(posedge core_clk) begin
      if (srst || r_q.st != ST_WAIT) pulse_len_q <= 10'h000;
      else pulse_len_q <= pulse_len_q + 10'h001;
   end
   a_strobe_needs_ce: assert property (@(posedge core_clk) disable iff (srst)
      !flash_we_n |-> !flash_ce_n && flash_dq_oe) else $error("write strobe without chip enable");
   a_no_bus_fight: assert property (@(posedge core_clk) disable iff (srst)
      !flash_oe_n |-> !flash_dq_oe && flash_we_n) else $error("read while driving data");
   a_strobe_width: assert property (@(posedge core_clk) disable iff (srst)
      $fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n) else $error("strobe width wrong");
   a_addr_stable: assert property (@(posedge core_clk) disable iff (srst)
      !flash_we_n |=> $stable(flash_addr) || flash_we_n) else $error("address moved in strobe");
   a_write_vpp: assert property (@(posedge core_clk) disable iff (srst)
      !flash_we_n |-> flash_vpp_en) else $error("write without program supply");
   a_prog_tries: assert property (@(posedge core_clk) disable iff (srst)
      r_q.op == OP_PROGRAM && r_q.busy |-> r_q.tries <= 10'(PROG_MAX_TRIES))
      else $error("too many program pulses");
   a_done_idle: assert property (@(posedge core_clk) disable iff (srst)
      done_pulse |-> req_ready ##1 !done_pulse) else $error("done not one cycle");
   a_pulse_length: assert property (@(posedge core_clk) disable iff (srst)
      $fell(r_q.st == ST_WAIT) && r_q.op == OP_PROGRAM |-> pulse_len_q == 10'(PROG_PULSE_CYC))
      else $error("program pulse length wrong");
endmodule : fcs_host
`default_nettype wire

// *** tb/fcs_flash_model.sv ***
// behavioural byte-wide flash device seen through its command register
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model
   import fcs_pkg::*;
#(
   parameter int ADDR_W = 2,
   parameter logic [7:0] MAKER_ID = 8'h5C, // arbitrary value
   parameter logic [7:0] PART_ID = 8'hE3 // arbitrary value
) (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] dq_host,
   input wire logic dq_oe,
   output logic [7:0] dq_dev,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic vpp
);
   logic [7:0] mem [2**ADDR_W];
   logic [7:0] cmd_q = CMD_READ;
   logic [2:0] st_q = 3'h0;
   logic [ADDR_W-1:0] a_fall = '0;
   logic [ADDR_W-1:0] ea_q = '0;
   logic [ADDR_W-1:0] pa_q = '0;
   logic [7:0] last_q = 8'h00;
   logic [7:0] rd;
   logic [7:0] prog_pulses = 8'h00;
   logic [7:0] erase_pulses = 8'h00;
   int n_erased = 0;
   initial for (int i = 0; i < 2**ADDR_W; i++) mem[i] = ERASED_BYTE;
   always @(negedge we_n) if (!ce_n) a_fall = addr;
   always @(negedge vpp) begin
      cmd_q = CMD_READ;
      st_q = 3'h0;
   end
   // commands take effect only with the supply up and the host driving the bus
   always @(posedge we_n) if (!ce_n && dq_oe && vpp) begin
      // each pulse erases one more byte, so the host must resume verify mid-array
      if (st_q == 3'h3) begin
         n_erased++;
         for (int i = 0; i < 2**ADDR_W; i++) if (i < n_erased) mem[i] = ERASED_BYTE;
         st_q = 3'h0;
      end else if (st_q == 3'h4) st_q = 3'h0;
      if (st_q == 3'h1 && dq_host == CMD_ERASE) begin
         st_q = 3'h3;
         erase_pulses++;
      end else if ((st_q == 3'h1 || st_q == 3'h2) && dq_host == CMD_RESET) st_q = 3'h5;
      else if (st_q == 3'h2) begin
         pa_q = a_fall;
         mem[a_fall] = mem[a_fall] & dq_host;
         n_erased = 0;
         prog_pulses++;
         st_q = 3'h4;
      end else if (st_q == 3'h5) st_q = 3'h0;
      else begin
         cmd_q = dq_host;
         if (dq_host == CMD_ERASE) st_q = 3'h1;
         if (dq_host == CMD_PROGRAM) st_q = 3'h2;
         if (dq_host == CMD_ERASE_VERIFY) ea_q = a_fall;
      end
   end
   always_comb begin
      case (cmd_q)
         CMD_IDENT: rd = addr[0] ? PART_ID : MAKER_ID;
         CMD_ERASE_VERIFY: rd = mem[ea_q];
         CMD_PROGRAM_VERIFY: rd = mem[pa_q];
         default: rd = mem[addr];
      endcase
   end
   // a released bus shows the inverse so a stale sample cannot pass
   always @(posedge oe_n) last_q = rd;
   assign dq_dev = (!ce_n && !oe_n) ? rd : ~last_q;
endmodule : fcs_flash_model
`default_nettype wire

// *** tb/test_flash_command_state_machine.sv ***
// self-checking bench of the flash command host against the device model
`timescale 1ns/10ps
`default_nettype none
module test_flash_command_state_machine;
   import fcs_pkg::*;
   localparam int AW = 2;
   localparam logic [7:0] MAKER = 8'h5C; // arbitrary value
   localparam logic [7:0] PART = 8'hE3; // arbitrary value
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0;
   logic [2:0] req_op = OP_READ;
   logic [AW-1:0] req_addr = '0;
   logic [7:0] req_data = 8'h00;
   logic req_ready, done_pulse, done_fail, dq_oe, ce_n, we_n, oe_n, vpp_en;
   logic [7:0] done_data, dq_out, dq_in;
   logic [AW-1:0] f_addr;
   logic [7:0] p0;
   int miscompares = 0;
   int n_tests = 0;
   always #12.5 core_clk = ~core_clk;
   fcs_host #(.ADDR_W(AW), .ERASE_CYC(20)) uut (.core_clk(core_clk), .srst(srst),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
      .req_ready(req_ready), .done_pulse(done_pulse), .done_fail(done_fail),
      .done_data(done_data), .flash_addr(f_addr), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n),
      .flash_oe_n(oe_n), .flash_vpp_en(vpp_en));
   fcs_flash_model #(.ADDR_W(AW), .MAKER_ID(MAKER), .PART_ID(PART)) dev (.addr(f_addr),
      .dq_host(dq_out), .dq_oe(dq_oe), .dq_dev(dq_in), .ce_n(ce_n), .we_n(we_n),
      .oe_n(oe_n), .vpp(vpp_en));
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic run_op(input logic [2:0] op, input logic [AW-1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      req_op = op;
      req_addr = a;
      req_data = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      n = 0;
      // done_pulse stands one cycle, so it is looked at on every falling edge
      while (done_pulse !== 1'b1 && n < 40000) begin
         @(negedge core_clk);
         n++;
      end
      cmp8({7'h00, done_pulse}, 8'h01);
   endtask : run_op
   task automatic t_ident;
      run_op(OP_IDENT, 2'h0, 8'h00);
      cmp8(done_data, MAKER);
      run_op(OP_IDENT, 2'h1, 8'h00);
      cmp8(done_data, PART);
      run_op(OP_READ, 2'h0, 8'h00);
      cmp8(dev.cmd_q, CMD_READ);
      $display("ident test done");
   endtask : t_ident
   task automatic t_program;
      run_op(OP_PROGRAM, 2'h2, 8'h5A);
      cmp8(done_data, 8'h5A);
      cmp8(dev.mem[2], 8'h5A);
      cmp8({7'h00, done_fail}, 8'h00);
      cmp8(dev.prog_pulses, 8'h01);
      run_op(OP_PROGRAM, 2'h0, 8'h3C);
      cmp8(dev.mem[0], 8'h3C);
      cmp8(dev.cmd_q, CMD_READ);
      cmp8({7'h00, vpp_en}, 8'h00);
      $display("program test done");
   endtask : t_program
   task automatic t_fail;
      // a bit cannot go back to one, so every verify mismatches
      p0 = dev.prog_pulses;
      run_op(OP_PROGRAM, 2'h2, 8'hA5);
      cmp8({7'h00, done_fail}, 8'h01);
      cmp8(dev.prog_pulses - p0, 8'h19);
      cmp8(dev.mem[2], 8'h00);
      $display("retry limit test done");
   endtask : t_fail
   task automatic t_abort;
      run_op(OP_ABORT, 2'h0, 8'h00);
      cmp8(dev.mem[2], 8'h00);
      cmp8(dev.mem[0], 8'h3C);
      cmp8({5'h00, dev.st_q}, 8'h00);
      $display("abort test done");
   endtask : t_abort
   task automatic t_erase;
      p0 = dev.erase_pulses;
      run_op(OP_ERASE, 2'h0, 8'h00);
      cmp8({7'h00, done_fail}, 8'h00);
      cmp8(dev.erase_pulses - p0, 8'h03);
      for (int i = 0; i < 4; i++) cmp8(dev.mem[i], ERASED_BYTE);
      $display("erase test done");
   endtask : t_erase
   initial begin
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      srst = 1'b0;
      cmp8({4'h0, ce_n, we_n, dq_oe, vpp_en}, 8'h0C);
      t_ident();
      t_program();
      t_fail();
      t_abort();
      t_erase();
      stop_test();
   end
   initial begin
      #2000000;
      miscompares++;
      stop_test();
   end
endmodule : test_flash_command_state_machine
`default_nettype wire
